// >>> verilog/tflp_consts.vh
// Constants for the timer flag and low-power block
`ifndef TFLP_CONSTS_VH
`define TFLP_CONSTS_VH
// =====================================================
// Register addresses
`define TFLP_ADDR_CTRL 8'h12
`define TFLP_ADDR_STATUS 8'h13
`define TFLP_ADDR_CAP_HI 8'h14
`define TFLP_ADDR_CAP_LO 8'h15
`define TFLP_ADDR_CMP_HI 8'h16
`define TFLP_ADDR_CMP_LO 8'h17
`define TFLP_ADDR_CNT_HI 8'h18
`define TFLP_ADDR_CNT_LO 8'h19
`define TFLP_ADDR_ALT_HI 8'h1a
`define TFLP_ADDR_ALT_LO 8'h1b
// =====================================================
// Status bit positions
`define TFLP_BIT_CAP 7
`define TFLP_BIT_CMP 6
`define TFLP_BIT_ROLL 5
// Control bit positions
`define TFLP_BIT_EDGE 1
`define TFLP_BIT_LEVEL 0
// =====================================================
// Counter values and timing
`define TFLP_CNT_RESET 16'hfffc
`define TFLP_CNT_MAX 16'hffff
`define TFLP_CNT_ZERO 16'h0000
`define TFLP_PRESCALE 2'h3
// =====================================================
// Vector addresses
`define TFLP_VEC_IRQ 16'h1ffa
`define TFLP_VEC_RESET 16'h1ffe
`define TFLP_VEC_WAIT_LO 16'h1ff4
// =====================================================
// Halt modes
`define TFLP_MODE_RUN 2'h0
`define TFLP_MODE_LIGHT 2'h1
`define TFLP_MODE_DEEP 2'h2
`endif

// >>> verilog/tflp_serial_gate.v
// Baud tick gating and receive abort for the async serial unit in deep halt
`timescale 1ns/1ps
`include "tflp_consts.vh"
module tflp_serial_gate (
   input wire CLOCK,
   input wire RST,
   input wire deep_halt,
   input wire baud_tick_in,
   input wire rx_busy,
   output reg baud_tick_out,
   output reg rx_abort
);
   reg deep_q;
   // =====================================================
   // Gating
   // Transmit state simply freezes without ticks, so it resumes afterwards
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         deep_q <= 1'b0;
         baud_tick_out <= 1'b0;
         rx_abort <= 1'b0;
      end else begin
         deep_q <= deep_halt;
         baud_tick_out <= baud_tick_in & ~deep_halt;
         rx_abort <= deep_halt & ~deep_q & rx_busy;
      end
   end
endmodule // tflp_serial_gate

// >>> verilog/tflp_timer.v
// Timer flags, counter, compare, capture and halt-mode control
`timescale 1ns/1ps
`include "tflp_consts.vh"
module tflp_timer (
   input wire CLOCK,
   input wire RST,
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire RD,
   input wire WR,
   output reg [7:0] RDATA,
   input wire CAPTURE_IN,
   output reg COMPARE_OUT_PIN,
   input wire ENTER_DEEP_HALT,
   input wire ENTER_LIGHT_HALT,
   input wire EXT_IRQ_N,
   input wire ANY_IRQ,
   input wire RESET_EXIT,
   output reg INT_MASK_CLEAR,
   output reg OSC_RUN,
   output reg CPU_RUN,
   output reg VECTOR_VALID,
   output reg [15:0] VECTOR_ADDR,
   input wire BAUD_TICK_IN,
   input wire RX_BUSY,
   output wire BAUD_TICK_OUT,
   output wire RX_ABORT
);
   reg [15:0] counter;
   reg [15:0] capture;
   reg [15:0] compare;
   reg [7:0] cnt_latch_lo;
   reg [7:0] cap_latch_lo;
   reg [7:0] ctrl;
   reg cap_flag;
   reg cmp_flag;
   reg roll_flag;
   reg cap_seen;
   reg cmp_seen;
   reg roll_seen;
   reg cmp_inhibit;
   reg [1:0] prescale;
   reg cap_in_q;
   reg [1:0] mode;
   reg [1:0] next_mode;
   wire deep_halt;
   wire tick;
   wire cap_edge;
   wire cmp_hit;
   wire rd_status;
   wire acc_cap_lo;
   wire acc_cmp_lo;
   wire acc_cnt_lo;
   wire wr_ctrl;
   wire wr_cmp_hi;
   wire wr_cmp_lo;
   wire set_cap;
   wire set_cmp;
   wire set_roll;
   wire clr_cap;
   wire clr_cmp;
   wire clr_roll;
   wire halt_exit;
   reg [15:0] next_counter;
   reg [1:0] next_prescale;
   reg next_cap_flag;
   reg next_cmp_flag;
   reg next_roll_flag;
   reg next_cap_seen;
   reg next_cmp_seen;
   reg next_roll_seen;

   // Decodes an access to one address
   function hit;
      input [7:0] a;
      input [7:0] target;
      input rd;
      input wr;
      begin
         hit = (a == target) && (rd || wr);
      end
   endfunction

   assign deep_halt = (mode == `TFLP_MODE_DEEP);
   // Counter runs from the processor clock divided by four
   assign tick = (prescale == `TFLP_PRESCALE) && !deep_halt;
   assign cap_edge = ctrl[`TFLP_BIT_EDGE] ? (CAPTURE_IN & ~cap_in_q)
                                          : (~CAPTURE_IN & cap_in_q);
   assign cmp_hit = tick && !cmp_inhibit && (compare == counter);
   assign rd_status = hit(ADDR, `TFLP_ADDR_STATUS, RD, 1'b0);
   assign acc_cap_lo = hit(ADDR, `TFLP_ADDR_CAP_LO, RD, WR);
   assign acc_cmp_lo = hit(ADDR, `TFLP_ADDR_CMP_LO, RD, WR);
   assign acc_cnt_lo = hit(ADDR, `TFLP_ADDR_CNT_LO, RD, WR);
   // One decode shared by the exit pulse and the vector choice
   assign halt_exit = (mode != `TFLP_MODE_RUN) && (next_mode == `TFLP_MODE_RUN);

   // =====================================================
   // Write strobes and flag events
   // Reads of the compare low byte do not unlock compares, only writes
   assign wr_ctrl = hit(ADDR, `TFLP_ADDR_CTRL, 1'b0, WR);
   assign wr_cmp_hi = hit(ADDR, `TFLP_ADDR_CMP_HI, 1'b0, WR);
   assign wr_cmp_lo = hit(ADDR, `TFLP_ADDR_CMP_LO, 1'b0, WR);
   assign set_cap = cap_edge && !deep_halt;
   assign set_cmp = cmp_hit;
   // Wrap is seen on the tick that leaves the top count
   assign set_roll = tick && (counter == `TFLP_CNT_MAX);
   // Only a flag recorded as set by the last status read may clear
   assign clr_cap = acc_cap_lo && cap_seen;
   assign clr_cmp = acc_cmp_lo && cmp_seen;
   assign clr_roll = acc_cnt_lo && roll_seen;

   // =====================================================
   // Halt mode state machine
   always @* begin
      next_mode = mode;
      case (mode)
         `TFLP_MODE_RUN: begin
            if (ENTER_DEEP_HALT)
               next_mode = `TFLP_MODE_DEEP;
            else if (ENTER_LIGHT_HALT)
               next_mode = `TFLP_MODE_LIGHT;
         end
         `TFLP_MODE_LIGHT: begin
            if (ANY_IRQ || RESET_EXIT)
               next_mode = `TFLP_MODE_RUN;
         end
         `TFLP_MODE_DEEP: begin
            if (!EXT_IRQ_N || RESET_EXIT)
               next_mode = `TFLP_MODE_RUN;
         end
         default: next_mode = `TFLP_MODE_RUN;
      endcase
   end

   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         mode <= `TFLP_MODE_RUN;
         INT_MASK_CLEAR <= 1'b0;
         OSC_RUN <= 1'b1;
         CPU_RUN <= 1'b1;
         VECTOR_VALID <= 1'b0;
         VECTOR_ADDR <= `TFLP_CNT_ZERO;
      end else begin
         mode <= next_mode;
         INT_MASK_CLEAR <= (mode == `TFLP_MODE_RUN) && (next_mode != `TFLP_MODE_RUN);
         OSC_RUN <= (next_mode != `TFLP_MODE_DEEP);
         CPU_RUN <= (next_mode == `TFLP_MODE_RUN);
         VECTOR_VALID <= halt_exit;
         if (halt_exit) begin
            // Interrupt exit from light halt takes the wait vector base; the CPU picks the slot
            if (RESET_EXIT)
               VECTOR_ADDR <= `TFLP_VEC_RESET;
            else if (mode == `TFLP_MODE_DEEP)
               VECTOR_ADDR <= `TFLP_VEC_IRQ;
            else
               VECTOR_ADDR <= `TFLP_VEC_WAIT_LO;
         end
      end
   end

   // =====================================================
   // Counter next state; deep halt freezes both counter and divider
   // Reset exit from deep halt restarts the divider so the first tick comes four clocks later
   always @* begin
      next_counter = counter;
      next_prescale = prescale;
      if (deep_halt && RESET_EXIT) begin
         next_counter = `TFLP_CNT_RESET;
         next_prescale = 2'h0;
      end else if (!deep_halt) begin
         // Prescaler keeps its phase across an interrupt exit from deep halt
         next_prescale = prescale + 2'h1;
         if (tick)
            next_counter = counter + 16'h0001;
      end
   end

   // =====================================================
   // Counter, prescaler, capture
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         counter <= `TFLP_CNT_RESET;
         prescale <= 2'h0;
         capture <= `TFLP_CNT_ZERO;
         cap_in_q <= 1'b0;
      end else begin
         cap_in_q <= CAPTURE_IN;
         counter <= next_counter;
         prescale <= next_prescale;
         if (cap_edge && !deep_halt)
            capture <= counter;
      end
   end

   // =====================================================
   // Control and compare registers
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctrl <= 8'h00;
         compare <= `TFLP_CNT_MAX;
         cmp_inhibit <= 1'b0;
         COMPARE_OUT_PIN <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl <= WDATA;
         // Compare lockout stays on until the low byte write completes the pair
         if (wr_cmp_hi) begin
            compare[15:8] <= WDATA;
            cmp_inhibit <= 1'b1;
         end
         if (wr_cmp_lo) begin
            compare[7:0] <= WDATA;
            cmp_inhibit <= 1'b0;
         end
         if (cmp_hit)
            COMPARE_OUT_PIN <= ctrl[`TFLP_BIT_LEVEL];
      end
   end

   // =====================================================
   // Status flags; a new set beats a clear in the same cycle
   // The record only lasts until the next matching low-byte access
   always @* begin
      next_cap_flag = cap_flag;
      next_cmp_flag = cmp_flag;
      next_roll_flag = roll_flag;
      next_cap_seen = cap_seen;
      next_cmp_seen = cmp_seen;
      next_roll_seen = roll_seen;
      if (rd_status) begin
         next_cap_seen = cap_flag;
         next_cmp_seen = cmp_flag;
         next_roll_seen = roll_flag;
      end else begin
         if (acc_cap_lo)
            next_cap_seen = 1'b0;
         if (acc_cmp_lo)
            next_cmp_seen = 1'b0;
         if (acc_cnt_lo)
            next_roll_seen = 1'b0;
      end
      if (set_cap)
         next_cap_flag = 1'b1;
      else if (clr_cap)
         next_cap_flag = 1'b0;
      if (set_cmp)
         next_cmp_flag = 1'b1;
      else if (clr_cmp)
         next_cmp_flag = 1'b0;
      if (set_roll)
         next_roll_flag = 1'b1;
      else if (clr_roll)
         next_roll_flag = 1'b0;
   end

   // =====================================================
   // Flag registers
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cap_flag <= 1'b0;
         cmp_flag <= 1'b0;
         roll_flag <= 1'b0;
         cap_seen <= 1'b0;
         cmp_seen <= 1'b0;
         roll_seen <= 1'b0;
      end else begin
         cap_flag <= next_cap_flag;
         cmp_flag <= next_cmp_flag;
         roll_flag <= next_roll_flag;
         cap_seen <= next_cap_seen;
         cmp_seen <= next_cmp_seen;
         roll_seen <= next_roll_seen;
      end
   end

   // =====================================================
   // Read path; capture and counter high byte reads freeze the low byte for coherent 16-bit reads
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         RDATA <= 8'h00;
         cnt_latch_lo <= 8'h00;
         cap_latch_lo <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            `TFLP_ADDR_CTRL: RDATA <= ctrl;
            `TFLP_ADDR_STATUS: RDATA <= {cap_flag, cmp_flag, roll_flag, 5'h00};
            `TFLP_ADDR_CAP_HI: begin
               RDATA <= capture[15:8];
               cap_latch_lo <= capture[7:0];
            end
            `TFLP_ADDR_CAP_LO: RDATA <= cap_latch_lo;
            `TFLP_ADDR_CMP_HI: RDATA <= compare[15:8];
            `TFLP_ADDR_CMP_LO: RDATA <= compare[7:0];
            `TFLP_ADDR_CNT_HI, `TFLP_ADDR_ALT_HI: begin
               RDATA <= counter[15:8];
               cnt_latch_lo <= counter[7:0];
            end
            `TFLP_ADDR_CNT_LO, `TFLP_ADDR_ALT_LO: RDATA <= cnt_latch_lo;
            default: RDATA <= 8'h00;
         endcase
      end
   end

   // =====================================================
   // Async serial unit gating in deep halt is done here by tflp_serial_gate
   tflp_serial_gate u_serial_gate (
      .CLOCK(CLOCK),
      .RST(RST),
      .deep_halt(deep_halt),
      .baud_tick_in(BAUD_TICK_IN),
      .rx_busy(RX_BUSY),
      .baud_tick_out(BAUD_TICK_OUT),
      .rx_abort(RX_ABORT)
   );
endmodule // tflp_timer

// >>> testbench/tflp_chk.sv
// Port checker for halt entry, halt exit and serial gating of the timer
`timescale 1ns/1ps
module tflp_chk (
   input wire CLOCK,
   input wire RST,
   input wire ENTER_DEEP_HALT,
   input wire ENTER_LIGHT_HALT,
   input wire EXT_IRQ_N,
   input wire ANY_IRQ,
   input wire RESET_EXIT,
   input wire INT_MASK_CLEAR,
   input wire OSC_RUN,
   input wire CPU_RUN,
   input wire VECTOR_VALID,
   input wire [15:0] VECTOR_ADDR,
   input wire BAUD_TICK_IN,
   input wire RX_BUSY,
   input wire BAUD_TICK_OUT,
   input wire RX_ABORT,
   input wire COMPARE_OUT_PIN
);
   // ============
   // Halt entry and exit
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   AST_DEEP_IN: assert property (
      ENTER_DEEP_HALT && CPU_RUN |=> !OSC_RUN && !CPU_RUN && INT_MASK_CLEAR)
      else $error("deep halt entry wrong");
   AST_LIGHT_IN: assert property (
      ENTER_LIGHT_HALT && !ENTER_DEEP_HALT && CPU_RUN |=> OSC_RUN && !CPU_RUN && INT_MASK_CLEAR)
      else $error("light halt entry wrong");
   AST_DEEP_OUT: assert property (
      !OSC_RUN && !EXT_IRQ_N && !RESET_EXIT |=> OSC_RUN && VECTOR_VALID && VECTOR_ADDR == 16'h1ffa)
      else $error("deep halt interrupt exit wrong");
   AST_LIGHT_OUT: assert property (
      !CPU_RUN && OSC_RUN && ANY_IRQ && !RESET_EXIT |=> VECTOR_VALID && VECTOR_ADDR == 16'h1ff4)
      else $error("light halt exit wrong");
   AST_RST_OUT: assert property (
      !CPU_RUN && RESET_EXIT |=> CPU_RUN && VECTOR_VALID && VECTOR_ADDR == 16'h1ffe)
      else $error("reset exit vector wrong");
   AST_OSC_WAKE: assert property (
      $rose(OSC_RUN) |-> $past(EXT_IRQ_N) == 1'b0 || $past(RESET_EXIT))
      else $error("oscillator restarted without cause");
   // ============
   // Serial gating and pin hold
   AST_RX_DROP: assert property (
      ENTER_DEEP_HALT && CPU_RUN && RX_BUSY |-> ##[1:2] RX_ABORT)
      else $error("receive not aborted");
   AST_BAUD_GO: assert property (
      BAUD_TICK_IN && OSC_RUN && !ENTER_DEEP_HALT |=> BAUD_TICK_OUT)
      else $error("baud tick lost while running");
   AST_BAUD_STOP: assert property (
      !OSC_RUN && !$past(OSC_RUN) |-> !BAUD_TICK_OUT)
      else $error("baud tick in deep halt");
   AST_PIN_HOLD: assert property (
      !OSC_RUN && !$past(OSC_RUN) |-> $stable(COMPARE_OUT_PIN))
      else $error("compare pin moved in deep halt");
endmodule // tflp_chk
bind tflp_timer tflp_chk tflp_chk_inst (.CLOCK(CLOCK), .RST(RST),
   .ENTER_DEEP_HALT(ENTER_DEEP_HALT), .ENTER_LIGHT_HALT(ENTER_LIGHT_HALT),
   .EXT_IRQ_N(EXT_IRQ_N), .ANY_IRQ(ANY_IRQ), .RESET_EXIT(RESET_EXIT),
   .INT_MASK_CLEAR(INT_MASK_CLEAR), .OSC_RUN(OSC_RUN), .CPU_RUN(CPU_RUN),
   .VECTOR_VALID(VECTOR_VALID), .VECTOR_ADDR(VECTOR_ADDR), .BAUD_TICK_IN(BAUD_TICK_IN),
   .RX_BUSY(RX_BUSY), .BAUD_TICK_OUT(BAUD_TICK_OUT), .RX_ABORT(RX_ABORT),
   .COMPARE_OUT_PIN(COMPARE_OUT_PIN));

// >>> testbench/tb_top.sv
// Self-checking bench for the timer flag and low-power block
`timescale 1ns/1ps
module tb_top;
   reg CLOCK = 0;
   reg RST = 1;
   reg [7:0] ADDR = 8'h00;
   reg [7:0] WDATA = 8'h00;
   reg RD = 0;
   reg WR = 0;
   reg CAPTURE_IN = 0;
   reg ENTER_DEEP_HALT = 0;
   reg ENTER_LIGHT_HALT = 0;
   reg EXT_IRQ_N = 1;
   reg ANY_IRQ = 0;
   reg RESET_EXIT = 0;
   reg BAUD_TICK_IN = 0;
   reg RX_BUSY = 1;
   wire [7:0] RDATA;
   wire COMPARE_OUT_PIN;
   wire VECTOR_VALID;
   wire [15:0] VECTOR_ADDR;
   integer mismatches = 0;
   integer compares = 0;
   integer i;
   reg [31:0] rnd = 68;
   reg [31:0] bnd = 68;
   reg [7:0] s;
   reg [15:0] a, b, d;
   tflp_timer tflp_timer_inst (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
      .RD(RD), .WR(WR), .RDATA(RDATA), .CAPTURE_IN(CAPTURE_IN),
      .COMPARE_OUT_PIN(COMPARE_OUT_PIN), .ENTER_DEEP_HALT(ENTER_DEEP_HALT),
      .ENTER_LIGHT_HALT(ENTER_LIGHT_HALT), .EXT_IRQ_N(EXT_IRQ_N), .ANY_IRQ(ANY_IRQ),
      .RESET_EXIT(RESET_EXIT), .INT_MASK_CLEAR(), .OSC_RUN(), .CPU_RUN(),
      .VECTOR_VALID(VECTOR_VALID), .VECTOR_ADDR(VECTOR_ADDR),
      .BAUD_TICK_IN(BAUD_TICK_IN), .RX_BUSY(RX_BUSY), .BAUD_TICK_OUT(), .RX_ABORT());
   // ============
   // Helpers
   function automatic [31:0] xs(input [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task chk(input [16:0] g, input [16:0] e);
      compares = compares + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task rd(input [7:0] ad, output [7:0] v);
      @(negedge CLOCK);
      ADDR = ad;
      RD = 1;
      @(negedge CLOCK);
      RD = 0;
      v = RDATA;
   endtask
   // High byte first, so the low byte comes from the same latch
   task rd16(input [7:0] ad, output [15:0] v);
      rd(ad, v[15:8]);
      rd(ad + 8'h01, v[7:0]);
   endtask
   task wr(input [7:0] ad, input [7:0] v);
      @(negedge CLOCK);
      ADDR = ad;
      WDATA = v;
      WR = 1;
      @(negedge CLOCK);
      WR = 0;
   endtask
   task pulse;
      @(negedge CLOCK);
      CAPTURE_IN = 1;
      repeat (4) @(negedge CLOCK);
      CAPTURE_IN = 0;
      repeat (4) @(negedge CLOCK);
   endtask
   // Exit kind: 0 external interrupt, 1 any interrupt, 2 reset
   task hlt(input deep, input [1:0] how, input [15:0] ev);
      @(negedge CLOCK);
      RX_BUSY = (how != 2'd2);
      ENTER_DEEP_HALT = deep;
      ENTER_LIGHT_HALT = !deep;
      @(negedge CLOCK);
      ENTER_DEEP_HALT = 0;
      ENTER_LIGHT_HALT = 0;
      repeat (40) @(negedge CLOCK);
      EXT_IRQ_N = (how != 2'd0);
      ANY_IRQ = (how == 2'd1);
      RESET_EXIT = (how == 2'd2);
      @(negedge CLOCK);
      chk({VECTOR_VALID, VECTOR_ADDR}, {1'b1, ev});
      EXT_IRQ_N = 1;
      ANY_IRQ = 0;
      RESET_EXIT = 0;
   endtask
   task print_verdict;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ============
   // Clock, random baud ticks, watchdog
   initial forever #10 CLOCK = ~CLOCK;
   always @(negedge CLOCK) begin
      bnd = xs(bnd);
      BAUD_TICK_IN = bnd[0];
   end
   initial begin
      repeat (20000) @(posedge CLOCK);
      mismatches = mismatches + 1;
      print_verdict;
   end
   // ============
   // Scenarios
   initial begin
      repeat (20) @(negedge CLOCK);
      RST = 0;
      repeat (20) @(negedge CLOCK);
      rd(8'h13, s);
      chk(s[5], 1);
      rd(8'h1b, s);
      rd(8'h13, s);
      chk(s[5], 1);
      rd(8'h19, s);
      rd(8'h13, s);
      chk(s[5], 0);
      for (i = 0; i < 4; i = i + 1) begin
         rnd = xs(rnd);
         rd16(8'h1a, a);
         repeat (4 * (rnd[5:0] + 1)) @(negedge CLOCK);
         rd16(8'h18, b);
         d = b - a;
         // Latch points lie 4 * (n + 2) clocks apart, one count per four clocks
         chk(d, rnd[5:0] + 16'd2);
      end
      wr(8'h12, 8'h03);
      pulse;
      rd(8'h13, s);
      chk(s[7], 1);
      rd16(8'h14, a);
      rd16(8'h1a, b);
      d = b - a;
      chk(d < 8, 1);
      rd(8'h13, s);
      chk(s[7], 0);
      pulse;
      rd(8'h15, s);
      rd(8'h13, s);
      chk(s[7], 1);
      rd(8'h17, s);
      rd16(8'h1a, d);
      d = d + 16'd30;
      // Low byte before high byte leaves compares locked out
      wr(8'h17, d[7:0]);
      wr(8'h16, d[15:8]);
      repeat (200) @(negedge CLOCK);
      rd(8'h13, s);
      chk({s[6], COMPARE_OUT_PIN}, 0);
      rd16(8'h1a, d);
      d = d + 16'd30;
      wr(8'h16, d[15:8]);
      wr(8'h17, d[7:0]);
      repeat (200) @(negedge CLOCK);
      rd(8'h13, s);
      chk({s[6], COMPARE_OUT_PIN}, 3);
      rd(8'h17, s);
      rd(8'h13, s);
      chk(s[6], 0);
      rd16(8'h1a, a);
      hlt(1, 0, 16'h1ffa);
      rd16(8'h1a, b);
      d = b - a;
      chk(d < 4, 1);
      hlt(0, 1, 16'h1ff4);
      rd16(8'h1a, a);
      d = a - b;
      chk(d > 8, 1);
      hlt(1, 2, 16'h1ffe);
      rd16(8'h18, a);
      d = a - 16'hfffc;
      chk(d < 3, 1);
      print_verdict;
   end
endmodule // tb_top
